// ---- logic/hop_mod_ctrl.sv ----
// hopping channel selection, synthesizer loading and on/off modulation
// assumes synchronous inputs on a 40 MHz mclk and a processor that feeds symbols
// no clock enable: every register updates on every rising mclk edge
// Operation
// - fifty channels, 0.5 MHz apart from 903 MHz
// - dwell 300 ms per channel
// - channel is seven-bit LFSR modulo fifty
// - LFSR steps from reset without pause
// - amplifier off until host transmit command
// - load synthesizer at reset and each hop
// - three symbols: clock, zero, one
// - one binary pulse: high on, low off
// - modulate while amplifier on unless unmodulated mode selected
// - keep hopping while carrier unmodulated
// - symbol order only from processor input
// - gaps between frames may vary
// - tag reply is one comparator bit
// - select one of nine antenna ports
`timescale 1ns/1ps
`include "hop_mod_map.svh"
module hop_mod_ctrl
  import hop_mod_pkg::*;
#(
  parameter int DWELL_CYC = `DWELL_CYC,
  parameter int CLK_ON    = `CLK_ON_CYC,
  parameter int CLK_OFF   = `CLK_OFF_CYC,
  parameter int ZERO_ON   = `ZERO_ON_CYC,
  parameter int ZERO_OFF  = `ZERO_OFF_CYC,
  parameter int ONE_ON    = `ONE_ON_CYC,
  parameter int ONE_OFF   = `ONE_OFF_CYC
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // host controls
  input  wire logic                   tx_cmd,
  input  wire logic                   tx_stop,
  input  wire logic                   unmod_sel,
  input  wire logic [3:0]             ant_sel,
  // symbol stream from the processor
  input  wire logic                   sym_valid,
  input  wire hop_mod_pkg::sym_e      sym_code,
  output logic                        sym_ready,
  // tag reply comparator
  input  wire logic                   tag_cmp,
  output logic                        tag_bit,
  // synthesizer serial port
  output logic                        syn_clk,
  output logic                        syn_data,
  output logic                        syn_le,
  // rf chain
  output logic                        pa_en,
  output logic                        rf_mod,
  output logic [8:0]                  ant_en,
  // status
  output logic [5:0]                  chan_num,
  output logic [19:0]                 chan_khz,
  output logic                        hop_pulse
);
  // dwell counter width follows the dwell length; symbol counters are 16 bits
  // so symbol phases up to 65535 cycles fit
  localparam int CW = $clog2(DWELL_CYC + 1);
  localparam int SW = 16;

  // one packed struct keeps every register under a single reset
  // whole module state
  typedef struct packed {
    logic [`LFSR_W-1:0]     lfsr;     // free-running sequence
    logic [CW-1:0]          dwell;    // cycles left on channel
    logic [5:0]             chan;     // channel 1..50
    logic [19:0]            khz;      // centre frequency in kHz
    logic                   hop;      // one-cycle hop marker
    syn_st_e                syn_st;   // loader state
    logic [`SYN_WORD_W-1:0] syn_sh;   // shift word
    logic [4:0]             syn_bits; // bits left
    logic [2:0]             syn_div;  // serial clock divider
    logic                   syn_ck;
    logic                   syn_d;
    logic                   syn_l;
    logic                   pa;       // amplifier power
    mod_st_e                mod_st;   // modulator state
    logic [SW-1:0]          mcnt;     // phase count
    logic [SW-1:0]          off_len;  // off time of current symbol
    logic                   rf;       // modulation pulse
    logic                   tag;      // registered comparator
    logic [8:0]             ant;      // antenna one-hot
  } st_s;
  st_s cur_ff, nxt_ff;

  logic   fb;         // lfsr feedback
  logic   buf_valid;  // buffered symbol waiting
  logic   buf_pop;    // modulator takes a symbol
  logic [1:0] buf_code;
  logic [6:0] resid;  // lfsr mod 50

  // per-port decode of the antenna index; one compare per port
  logic [`NUM_ANT-1:0] ant_hit; // port k addressed
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_ANT; gi++) begin : g_ant
      assign ant_hit[gi] = (ant_sel == 4'(gi));
    end
  endgenerate

  // two-entry buffer so a busy modulator loses no symbol
  sym_buf #(.W(2)) u_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (sym_valid),
    .in_data   (sym_code),
    .in_ready  (sym_ready),
    .out_valid (buf_valid),
    .out_data  (buf_code),
    .out_ready (buf_pop)
  );

  // symbols wait in the buffer while the amplifier is off or unmodulated
  // modulator pops only when idle and transmitting in modulated mode
  assign buf_pop = buf_valid && (cur_ff.mod_st == MOD_IDLE) && cur_ff.pa && !unmod_sel;

  // next-state logic for hopping, loading and modulating
  always_comb begin
    // every field holds unless a branch below changes it
    nxt_ff = cur_ff;
    nxt_ff.hop = 1'b0;
    // xnor-free fibonacci taps 7,6 give a 127-state sequence
    fb = ^(cur_ff.lfsr & `LFSR_TAP);
    nxt_ff.lfsr = {cur_ff.lfsr[`LFSR_W-2:0], fb};
    // an all-zero register would freeze the sequence; reseed instead
    if (cur_ff.lfsr == '0) begin
      nxt_ff.lfsr = `LFSR_SEED;
    end
    // residue 0..49 picks channel 1..50
    resid = cur_ff.lfsr;
    // a 7-bit value is below 150, so one subtraction of 100 or 50 is enough
    if (resid >= 7'd100) begin
      resid = resid - 7'd100;
    end else if (resid >= 7'd50) begin
      resid = resid - 7'd50;
    end
    // dwell timer keeps running in every mode, so hopping never stops
    if (cur_ff.dwell == '0) begin
      nxt_ff.dwell = CW'(DWELL_CYC - 1);
      nxt_ff.chan  = 6'(resid) + 6'h01;
      nxt_ff.khz   = 20'(`CHAN_BASE_KHZ + 32'(resid) * `CHAN_STEP_KHZ);
      nxt_ff.hop   = 1'b1;
    end else begin
      // count down to the next hop
      nxt_ff.dwell = cur_ff.dwell - CW'(1);
    end
    // synthesizer loader; a hop aborts any unfinished load and restarts
    case (cur_ff.syn_st)
      SYN_IDLE: begin
        // nothing to send; latch enable stays low
        nxt_ff.syn_l = 1'b0;
      end
      SYN_SHIFT: begin
        // divide mclk down to the serial clock and move one bit per period
        nxt_ff.syn_div = cur_ff.syn_div + 3'h1;
        if (cur_ff.syn_div == 3'(`SYN_HALF_CYC - 1)) begin
          nxt_ff.syn_div = 3'h0;
          nxt_ff.syn_ck  = ~cur_ff.syn_ck;
          // data moves on the falling edge, synthesizer samples on rising
          if (cur_ff.syn_ck) begin
            if (cur_ff.syn_bits == 5'h0) begin
              nxt_ff.syn_st = SYN_LATCH;
              nxt_ff.syn_l  = 1'b1;
            end else begin
              nxt_ff.syn_d    = cur_ff.syn_sh[`SYN_WORD_W-1];
              nxt_ff.syn_sh   = {cur_ff.syn_sh[`SYN_WORD_W-2:0], 1'b0};
              nxt_ff.syn_bits = cur_ff.syn_bits - 5'h1;
            end
          end
        end
      end
      SYN_LATCH: begin
        // one-cycle latch pulse copies the word into the synthesizer
        nxt_ff.syn_l  = 1'b0;
        nxt_ff.syn_st = SYN_IDLE;
      end
      default: begin
        // illegal code: return to idle
        nxt_ff.syn_st = SYN_IDLE;
      end
    endcase
    // a fresh hop wins over the loader: the newest channel is what counts
    // the word is the new centre frequency, sent msb first
    if (nxt_ff.hop) begin
      nxt_ff.syn_st   = SYN_SHIFT;
      nxt_ff.syn_sh   = nxt_ff.khz;
      nxt_ff.syn_bits = 5'(`SYN_WORD_W);
      nxt_ff.syn_div  = 3'h0;
      nxt_ff.syn_ck   = 1'b0;
      nxt_ff.syn_l    = 1'b0;
    end
    // amplifier power: stop wins over a simultaneous transmit command
    // pa_en is a level; a host command of one cycle or longer is enough
    if (tx_stop) begin
      nxt_ff.pa = 1'b0;
    end else if (tx_cmd) begin
      nxt_ff.pa = 1'b1;
    end
    // modulator: each symbol is an on phase then an off phase
    // limitation: durations are fixed at build time, not run-time settings
    case (cur_ff.mod_st)
      MOD_IDLE: begin
        // idle level is carrier on; gaps follow processor latency
        nxt_ff.rf = 1'b1;
        if (buf_pop) begin
          nxt_ff.mod_st = MOD_ON;
          // code 3 is unused and plays as a clock
          case (buf_code)
            SYM_ZERO: begin
              nxt_ff.mcnt    = SW'(ZERO_ON - 1);
              nxt_ff.off_len = SW'(ZERO_OFF - 1);
            end
            SYM_ONE: begin
              nxt_ff.mcnt    = SW'(ONE_ON - 1);
              nxt_ff.off_len = SW'(ONE_OFF - 1);
            end
            default: begin
              nxt_ff.mcnt    = SW'(CLK_ON - 1);
              nxt_ff.off_len = SW'(CLK_OFF - 1);
            end
          endcase
        end
      end
      MOD_ON: begin
        // carrier on for the symbol's on time
        nxt_ff.rf = 1'b1;
        if (cur_ff.mcnt == '0) begin
          nxt_ff.mod_st = MOD_OFF;
          nxt_ff.mcnt   = cur_ff.off_len;
          nxt_ff.rf     = 1'b0;
        end else begin
          nxt_ff.mcnt = cur_ff.mcnt - SW'(1);
        end
      end
      MOD_OFF: begin
        // carrier off; this gap and the on time together tell the tag the symbol
        nxt_ff.rf = 1'b0;
        if (cur_ff.mcnt == '0) begin
          nxt_ff.mod_st = MOD_IDLE;
          nxt_ff.rf     = 1'b1;
        end else begin
          nxt_ff.mcnt = cur_ff.mcnt - SW'(1);
        end
      end
      default: begin
        // illegal code: back to idle with carrier on
        nxt_ff.mod_st = MOD_IDLE;
        nxt_ff.rf     = 1'b1;
      end
    endcase
    // unmodulated mode or amplifier off aborts any symbol: steady carrier
    if (unmod_sel || !nxt_ff.pa) begin
      nxt_ff.mod_st = MOD_IDLE;
      nxt_ff.rf     = 1'b1;
    end
    // comparator bit is taken straight, already synchronous
    // limitation: no filtering; decoding tag replies is the processor's job
    nxt_ff.tag = tag_cmp;
    // one antenna port; codes above eight keep the current port
    if (|ant_hit) begin
      nxt_ff.ant = ant_hit;
    end
  end

  // state register; reset forces an immediate hop, so the first load starts at once
  // carrier idles on after reset so tags in the field stay powered
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_ff        <= '0;
      cur_ff.lfsr   <= `LFSR_SEED;
      cur_ff.syn_st <= SYN_IDLE;
      cur_ff.mod_st <= MOD_IDLE;
      cur_ff.rf     <= 1'b1;
      cur_ff.ant    <= 9'h001;
      cur_ff.chan   <= 6'h01;
      cur_ff.khz    <= 20'(`CHAN_BASE_KHZ);
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs straight from state flip-flops
  // nothing combinational reaches a pin, so the rf chain sees clean edges
  assign tag_bit   = cur_ff.tag;
  assign syn_clk   = cur_ff.syn_ck;
  assign syn_data  = cur_ff.syn_d;
  assign syn_le    = cur_ff.syn_l;
  assign pa_en     = cur_ff.pa;
  assign rf_mod    = cur_ff.rf;
  assign ant_en    = cur_ff.ant;
  assign chan_num  = cur_ff.chan;
  assign chan_khz  = cur_ff.khz;
  assign hop_pulse = cur_ff.hop;
endmodule

// ---- logic/hop_mod_map.svh ----
// constants for the hopping and on/off modulation controller
// assumes a 40 MHz mclk; included by bare name
`ifndef HOP_MOD_MAP_SVH
`define HOP_MOD_MAP_SVH
`define CLK_HZ          40000000
`define NUM_CHAN        50
`define CHAN_STEP_KHZ   500
`define CHAN_BASE_KHZ   903000
`define DWELL_MS        300
`define DWELL_CYC       ((`DWELL_MS * (`CLK_HZ / 1000)))
`define LFSR_W          7
`define LFSR_SEED       7'h01
`define LFSR_TAP        7'h60
`define SYN_WORD_W      20
`define SYN_HALF_CYC    4
`define NUM_ANT         9
`define CLK_ON_CYC      400
`define CLK_OFF_CYC     400
`define ZERO_ON_CYC     400
`define ZERO_OFF_CYC    800
`define ONE_ON_CYC      800
`define ONE_OFF_CYC     400
`endif

// ---- logic/hop_mod_pkg.sv ----
// types shared by the hopping and modulation controller
// assumes nothing beyond a SystemVerilog compiler
package hop_mod_pkg;
  // transmit symbol kinds
  typedef enum logic [1:0] {
    SYM_CLOCK = 2'h0,
    SYM_ZERO  = 2'h1,
    SYM_ONE   = 2'h2
  } sym_e;
  // modulator states, one-hot
  typedef enum logic [2:0] {
    MOD_IDLE = 3'h1,
    MOD_ON   = 3'h2,
    MOD_OFF  = 3'h4
  } mod_st_e;
  // synthesizer loader states, one-hot
  typedef enum logic [2:0] {
    SYN_IDLE = 3'h1,
    SYN_SHIFT = 3'h2,
    SYN_LATCH = 3'h4
  } syn_st_e;
endpackage

// ---- logic/sym_buf.sv ----
// two-entry buffer for symbol codes between the processor and the modulator
// assumes one clock; valid/ready handshakes on both sides
`timescale 1ns/1ps
module sym_buf #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;   // two entries
    logic              wp;    // write slot
    logic              rp;    // read slot
    logic [1:0]        cnt;   // fill level 0..2
    logic [W-1:0]      dout;  // registered head
    logic              rdy;   // registered room flag, drives in_ready
    logic              vld;   // registered data flag, drives out_valid
  } buf_s;
  buf_s cur_ff, nxt_ff;
  logic push, pop;

  // handshakes and next state; head data always comes from a register
  always_comb begin
    nxt_ff = cur_ff;
    push   = in_valid && (cur_ff.cnt != 2'h2);
    pop    = out_ready && (cur_ff.cnt != 2'h0);
    if (push) begin
      nxt_ff.mem[cur_ff.wp] = in_data;
      nxt_ff.wp             = ~cur_ff.wp;
    end
    if (pop) begin
      nxt_ff.rp = ~cur_ff.rp;
    end
    nxt_ff.cnt  = cur_ff.cnt + {1'b0, push} - {1'b0, pop};
    nxt_ff.dout = nxt_ff.mem[nxt_ff.rp];
    nxt_ff.rdy  = (nxt_ff.cnt != 2'h2);
    nxt_ff.vld  = (nxt_ff.cnt != 2'h0);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_ff     <= '0;
      cur_ff.rdy <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign in_ready  = cur_ff.rdy;
  assign out_valid = cur_ff.vld;
  assign out_data  = cur_ff.dout;
endmodule

// ---- verif/freq_hop_onoff_modulation_ctrl_bench.sv ----
// self-checking bench for the hopping and on/off modulation controller
// assumes the design, the checker and the far side model are compiled first
`timescale 1ns/1ps
module freq_hop_onoff_modulation_ctrl_bench;
  import hop_mod_pkg::*;
  localparam int DWELL = 200; // short dwell so several hops fit the run
  localparam int ON_LEN = 4;  // on time shared by all symbols
  localparam int GAP_CLK = 4; // off time of a clock
  localparam int GAP_ZERO = 6; // off time of a zero
  localparam int GAP_ONE = 8;  // off time of a one
  logic mclk, rst_n, tx_cmd, tx_stop, unmod_sel, sym_valid, sym_ready, tag_cmp, tag_bit;
  logic syn_clk, syn_data, syn_le, pa_en, rf_mod, hop_pulse, last_cmp;
  logic [3:0]  ant_sel;
  logic [8:0]  ant_en, exp_ant;
  logic [5:0]  chan_num;
  logic [19:0] chan_khz, syn_word, exp_khz;
  logic [6:0]  lfsr, prev; // mirror of the channel shift register
  sym_e        sym_code;
  sym_e        q[$];       // symbols taken, awaiting their rf gap
  int          failures, total_checks, hops, low_run, cycles, h;
  hop_mod_ctrl #(.DWELL_CYC(DWELL), .CLK_ON(ON_LEN), .CLK_OFF(GAP_CLK), .ZERO_ON(ON_LEN),
    .ZERO_OFF(GAP_ZERO), .ONE_ON(ON_LEN), .ONE_OFF(GAP_ONE)) i_dut (.mclk, .rst_n, .tx_cmd,
    .tx_stop, .unmod_sel, .ant_sel,
    .sym_valid, .sym_code, .sym_ready, .tag_cmp, .tag_bit, .syn_clk, .syn_data, .syn_le,
    .pa_en, .rf_mod, .ant_en, .chan_num, .chan_khz, .hop_pulse);
  hop_far_side i_far (.syn_clk, .syn_data, .rf_mod, .syn_word, .tag_cmp);
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task summarize();
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic int off_len(input sym_e c);
    case (c)
      SYM_ZERO: return GAP_ZERO;
      SYM_ONE:  return GAP_ONE;
      default:  return GAP_CLK; // code 3 plays as a clock
    endcase
  endfunction
  // offer one symbol and hold it until taken
  task send(input sym_e c);
    sym_valid <= 1'b1;
    sym_code  <= c;
    @(negedge mclk);
    while (sym_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    q.push_back(c);
  endtask
  // wait, bounded, until every taken symbol has played
  task drain();
    for (int i = 0; i < 400 && (q.size() > 0 || low_run > 0); i++) @(negedge mclk);
    check(q.size(), 0);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end
  // model: shift register mirror and tag echo, stepping with the design
  always @(posedge mclk) begin
    prev     <= lfsr;
    lfsr     <= rst_n ? {lfsr[5:0], lfsr[6] ^ lfsr[5]} : 7'h01;
    last_cmp <= tag_cmp;
  end
  // compare every result where outputs have settled
  always @(negedge mclk) if (rst_n) begin
    check(tag_bit, last_cmp);
    if (hop_pulse) begin
      check(chan_num, prev % 50 + 1);
      check(chan_khz, 903000 + 500 * (prev % 50));
      exp_khz = 20'(903000 + 500 * (prev % 50));
      hops++;
    end
    if (syn_le) check(syn_word, exp_khz);
    if (!rf_mod) low_run++;
    else if (low_run > 0) begin
      check(low_run, q.size() > 0 ? off_len(q.pop_front()) : 0);
      low_run = 0;
    end
  end
  initial begin
    {rst_n, tx_cmd, tx_stop, unmod_sel, sym_valid} = 5'h00;
    ant_sel  = 4'h0;
    sym_code = SYM_CLOCK;
    h        = $urandom(9337);
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check({pa_en, rf_mod, sym_ready}, 3'h3);
    check(ant_en, 9'h001);
    check(chan_num, 6'h01);
    @(posedge mclk) rst_n <= 1'b1;
    // antenna sweep, out-of-range indexes keep the last port
    exp_ant = 9'h001;
    for (int i = 0; i < 11; i++) begin
      ant_sel <= 4'(i);
      @(posedge mclk);
      @(negedge mclk);
      if (i < 9) exp_ant = 9'h001 << i;
      check(ant_en, exp_ant);
      @(posedge mclk);
    end
    // amplifier off: buffer fills and refuses, nothing plays
    send(SYM_ONE);
    send(SYM_ZERO);
    sym_valid <= 1'b0;
    repeat (20) @(negedge mclk);
    check({sym_ready, pa_en, rf_mod}, 3'h1);
    @(posedge mclk) tx_cmd <= 1'b1;
    @(posedge mclk) tx_cmd <= 1'b0;
    @(negedge mclk) check(pa_en, 1'b1);
    // back-to-back random symbols, all codes
    @(posedge mclk);
    send(SYM_CLOCK);
    for (int i = 0; i < 12; i++) send(sym_e'($urandom % 4));
    sym_valid <= 1'b0;
    drain();
    // unmodulated carrier: symbol held back, hopping goes on
    @(posedge mclk) unmod_sel <= 1'b1;
    send(SYM_ZERO);
    sym_valid <= 1'b0;
    h = hops;
    for (int i = 0; i < 2 * DWELL + 10 && hops < h + 2; i++) @(negedge mclk);
    check(hops >= h + 2, 1'b1);
    check(q.size(), 1);
    @(posedge mclk) unmod_sel <= 1'b0;
    drain();
    // stop wins over a simultaneous transmit command
    @(posedge mclk);
    tx_stop <= 1'b1;
    tx_cmd  <= 1'b1;
    @(posedge mclk);
    tx_stop <= 1'b0;
    tx_cmd  <= 1'b0;
    @(negedge mclk) check(pa_en, 1'b0);
    summarize();
  end
endmodule
bind hop_mod_ctrl hop_mod_ctrl_checker #(.DWELL_CYC(DWELL_CYC)) i_chk (.mclk, .rst_n, .tx_cmd,
  .tx_stop, .unmod_sel, .ant_sel, .tag_cmp, .tag_bit, .syn_clk, .syn_data, .syn_le, .pa_en,
  .rf_mod, .ant_en, .chan_num, .chan_khz, .hop_pulse);

// ---- verif/hop_far_side.sv ----
// far side model: synthesizer shift port and a tag in the field
// assumes the controller's serial port and modulation pulse
`timescale 1ns/1ps
module hop_far_side (
  // synthesizer serial port
  input  wire logic   syn_clk,
  input  wire logic   syn_data,
  // rf pulse and tag reply
  input  wire logic   rf_mod,
  output logic [19:0] syn_word,
  output logic        tag_cmp
);
  // start from a known word and a quiet tag
  initial begin
    syn_word = 20'h00000;
    tag_cmp  = 1'b0;
  end
  // shift in msb first on the rising serial clock
  always @(posedge syn_clk) syn_word <= {syn_word[18:0], syn_data};
  // tag answers each rf gap with a new backscatter level
  always @(negedge rf_mod) tag_cmp <= ~tag_cmp;
endmodule

// ---- verif/hop_mod_ctrl_checker.sv ----
// checker for the hopping and on/off modulation controller
// assumes a bind to hop_mod_ctrl with off times of 4, 6 and 8 cycles
`timescale 1ns/1ps
module hop_mod_ctrl_checker #(
  parameter int DWELL_CYC = 200
) (
  // clock, reset and host controls
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        tx_cmd,
  input wire logic        tx_stop,
  input wire logic        unmod_sel,
  input wire logic [3:0]  ant_sel,
  // tag reply and synthesizer port
  input wire logic        tag_cmp,
  input wire logic        tag_bit,
  input wire logic        syn_clk,
  input wire logic        syn_data,
  input wire logic        syn_le,
  // rf chain and status
  input wire logic        pa_en,
  input wire logic        rf_mod,
  input wire logic [8:0]  ant_en,
  input wire logic [5:0]  chan_num,
  input wire logic [19:0] chan_khz,
  input wire logic        hop_pulse
);
  int   gap_ff;  // cycles since the last hop
  logic seen_ff; // first hop seen, so gaps are meaningful
  // count the dwell; a counter because a repetition cannot reach 200
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gap_ff  <= 0;
      seen_ff <= 1'b0;
    end else if (hop_pulse) begin
      gap_ff  <= 1;
      seen_ff <= 1'b1;
    end else begin
      gap_ff  <= gap_ff + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // the three rf gap lengths of clock, zero and one
  sequence s_off4; !rf_mod [*4] ##1 rf_mod; endsequence
  sequence s_off6; !rf_mod [*6] ##1 rf_mod; endsequence
  sequence s_off8; !rf_mod [*8] ##1 rf_mod; endsequence
  property p_pa_on; tx_cmd && !tx_stop |=> pa_en; endproperty
  property p_pa_off; tx_stop |=> !pa_en; endproperty
  property p_hop_gap; hop_pulse && seen_ff |-> gap_ff == DWELL_CYC; endproperty
  property p_chan;
    hop_pulse |-> chan_num inside {[1:50]} && chan_khz == 903000 + 500 * (chan_num - 1);
  endproperty
  property p_ant; ant_sel < 4'h9 |=> ant_en == 9'h001 << $past(ant_sel); endproperty
  property p_tag; $past(rst_n) |-> tag_bit == $past(tag_cmp); endproperty
  property p_unmod; $past(unmod_sel) |-> rf_mod; endproperty
  property p_syn_clk;
    $rose(syn_clk) |=> (syn_clk && $stable(syn_data)) [*3] ##1 !syn_clk;
  endproperty
  property p_le; $rose(syn_le) |=> !syn_le; endproperty
  property p_off; $fell(rf_mod) |-> s_off4 or s_off6 or s_off8; endproperty
  a_pa_on: assert property (p_pa_on) else $error("amplifier not on");
  a_pa_off: assert property (p_pa_off) else $error("amplifier not off");
  a_hop_gap: assert property (p_hop_gap) else $error("dwell length wrong");
  a_chan: assert property (p_chan) else $error("channel out of plan");
  a_ant: assert property (p_ant) else $error("antenna enable wrong");
  a_tag: assert property (p_tag) else $error("tag bit not echoed");
  a_unmod: assert property (p_unmod) else $error("rf gated while unmodulated");
  a_syn_clk: assert property (p_syn_clk) else $error("serial clock shape wrong");
  a_le: assert property (p_le) else $error("latch pulse too long");
  a_off: assert property (p_off) else $error("rf gap length wrong");
endmodule
